// ---- core/acdp_port.v ----
// Purpose: Ancillary/control data port with register file and pin bank.
// Assumes: Port clock is slow against clk and sampled as a plain input.
// Notes:   Rules of the port follow, one per line.
// Operation
// R1: Low eight bits carry data, top two handshake
// R2: Host marks addresses with upper code 00
// R3: Host marks write data with upper code 11
// R4: Read data driven with upper code 10
// R5: Host gives three port clocks after reset
// R6: Control low, read high selects register read
// R7: Address captured on port clock rising edge
// R8: Read data driven until next rising edge
// R9: Host releases bus after read address
// R10: Second read clock returns port to receive
// R11: Register 01 returns full-field flags bits 4:0
// R12: Both selects low selects register write
// R13: Second write edge stores data into register
// R14: Host removes values by the falling edge
// R15: Ancillary write: control high, read low, DID first
// R16: Each ancillary word taken on rising edge
// R17: FIFO written only in ancillary mode, never read
// R18: Host loads ancillary data during active video
// R19: Checksum supplied or generated per configuration
// R20: Flag sequence prepended to every packet
// R21: Two extra clocks flush double buffer
// R22: SD uses blanking, HD chroma channel only
// R23: Each pin has six-bit select register
// R24: Select input steers edges to FIFO or registers
// R25: Port clock no faster than video clock
// R26: Reset returns sequencer idle, bus released
`default_nettype none
`include "acdp_map.vh"

module acdp_port (
    input  wire                         clk,          // Core clock, 100 MHz
    input  wire                         reset_n,      // Async reset, active low
    input  wire                         port_clk,     // Port clock pin
    input  wire                         anc_ctrl_sel, // High: ancillary, low: control
    input  wire                         rd_wr_sel,    // High: read, low: write
    input  wire [`ACDP_AD_W-1:0]        ad_in,        // Port bus input
    output wire [`ACDP_AD_W-1:0]        ad_out,       // Port bus output
    output wire                         ad_oe_n,      // Bus enable, low drives
    input  wire [`ACDP_NPINS-1:0]       io_pin_in,    // Multi-function pin inputs
    output wire [`ACDP_NPINS-1:0]       io_pin_out,   // Multi-function pin outputs
    output wire [`ACDP_NPINS-1:0]       io_pin_oe_n,  // Pin enables, low drives
    input  wire [4:0]                   ff_err_set,   // Full-field error events
    input  wire                         video_is_hd,  // HD raster from video path
    output wire [`ACDP_DAT_W-1:0]       test_pattern_setup, // Pattern setup register
    output wire                         anc_push,     // FIFO write strobe
    output wire [`ACDP_AD_W-1:0]        anc_word,     // FIFO write word
    output wire                         anc_sop,      // First word of a packet
    output wire                         anc_chroma_only // Packet goes to chroma lane
);

    localparam C_INIT  = 2'h0;
    localparam C_ADDR  = 2'h1;
    localparam C_RD    = 2'h2;
    localparam C_WDATA = 2'h3;
    localparam E_IDLE = 3'h0;
    localparam E_ADF0 = 3'h1;
    localparam E_ADF1 = 3'h2;
    localparam E_ADF2 = 3'h3;
    localparam E_WORD = 3'h4;
    localparam E_SUM  = 3'h5;

    reg  [`ACDP_DAT_W-1:0]   mem [0:`ACDP_NREG-1];
    wire [`ACDP_SYNC_W-1:0]  s_vec;
    wire                     s_clk;
    wire                     s_anc;
    wire                     s_rd;
    wire [`ACDP_AD_W-1:0]    s_ad;
    wire [`ACDP_NPINS-1:0]   s_pin;
    reg                      clk_d_ff;
    wire                     edge_any;
    wire                     ctrl_edge;
    wire                     anc_edge;
    reg  [1:0]               state_ff;
    reg  [1:0]               init_cnt_ff;
    reg  [7:0]               addr_ff;
    reg  [`ACDP_AD_W-1:0]    ad_out_ff;
    reg                      ad_oe_n_ff;
    wire                     wr_go;
    reg  [`ACDP_AD_W-1:0]    st1_ff;
    reg                      st1_v_ff;
    reg  [`ACDP_AD_W-1:0]    st2_ff;
    reg                      st2_v_ff;
    reg  [1:0]               pos_ff;
    reg  [7:0]               udw_left_ff;
    reg  [8:0]               sum_ff;
    wire [9:0]               sum_wide;
    wire [8:0]               sum_new;
    wire                     csum_int;
    reg                      take_first;
    reg                      take_sum;
    reg  [2:0]               emit_ff;
    reg  [`ACDP_AD_W-1:0]    hold_ff;
    reg                      hold_sum_ff;
    reg  [`ACDP_AD_W-1:0]    csum_ff;
    reg                      push_ff;
    reg  [`ACDP_AD_W-1:0]    word_ff;
    reg                      sop_ff;
    reg                      chroma_ff;
    wire [`ACDP_NPINS-1:0]   pin_val;
    reg  [`ACDP_NPINS-1:0]   pin_out_ff;
    reg  [`ACDP_NPINS-1:0]   pin_oe_n_ff;
    integer                  i;

    // Index inside the register file, low five address bits
    function [`ACDP_IDX_W-1:0] reg_idx;
        input [7:0] a;
        begin
            reg_idx = a[`ACDP_IDX_W-1:0];
        end
    endfunction

    // Address falls inside the implemented register file
    function reg_hit;
        input [7:0] a;
        begin
            reg_hit = (a[7:`ACDP_IDX_W] == 3'h0);
        end
    endfunction

    // Writable bits of each register
    function [7:0] wmask;
        input [`ACDP_IDX_W-1:0] idx;
        begin
            if (idx >= `ACDP_REG_IOCFG0 && idx < `ACDP_REG_IODIR)
                wmask = `ACDP_IOCFG_MASK;
            else
                wmask = `ACDP_FULL_MASK;
        end
    endfunction

    // Pin select code: upper field names the register
    function [`ACDP_IDX_W-1:0] cfg_reg;
        input [`ACDP_CFG_W-1:0] code;
        begin
            cfg_reg = {2'h0, code[5:3]};
        end
    endfunction

    // Pin select code: lower field names the bit
    function [2:0] cfg_bit;
        input [`ACDP_CFG_W-1:0] code;
        begin
            cfg_bit = code[2:0];
        end
    endfunction

    // All pins share one synchroniser instance
    acdp_sync #(
        .W       (`ACDP_SYNC_W)
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       ({io_pin_in, ad_in, rd_wr_sel, anc_ctrl_sel, port_clk}),
        .q       (s_vec)
    );

    assign s_clk = s_vec[`ACDP_S_CLK];
    assign s_anc = s_vec[`ACDP_S_ANC];
    assign s_rd  = s_vec[`ACDP_S_RD];
    assign s_ad  = s_vec[`ACDP_S_AD_LO +: `ACDP_AD_W];
    assign s_pin = s_vec[`ACDP_S_PIN_LO +: `ACDP_NPINS];

    // Rising-edge finder on the synchronised port clock
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            clk_d_ff <= 1'b0;
        else
            clk_d_ff <= s_clk;
    end

    // Bus values are sampled with the edge; host holds them to the fall
    assign edge_any  = s_clk & ~clk_d_ff;
    assign ctrl_edge = edge_any & ~s_anc & (state_ff != C_INIT); // [R24]
    assign anc_edge  = edge_any & s_anc & (state_ff != C_INIT);  // [R24] [R17]

    // Control sequencer: address phase, then drive or data phase
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff    <= C_INIT;            // [R26]
            init_cnt_ff <= 2'h0;
            addr_ff     <= 8'h00;
            ad_out_ff   <= {`ACDP_AD_W{1'b0}};
            ad_oe_n_ff  <= 1'b1;              // [R26]
        end
        else if (state_ff == C_INIT)
        begin
            // Start-up clocks are swallowed before the port listens
            if (edge_any)
            begin
                init_cnt_ff <= init_cnt_ff + 2'h1;
                if (init_cnt_ff == `ACDP_INIT_EDGES - 2'h1)
                    state_ff <= C_ADDR;       // [R5]
            end
        end
        else if (ctrl_edge)
        begin
            case (state_ff)
                C_ADDR:
                begin
                    // Wrong handshake code is not taken as an address
                    if (s_ad[9:8] == `ACDP_HS_ADDR)               // [R1] [R2]
                    begin
                        addr_ff <= s_ad[7:0];                    // [R7]
                        if (s_rd)                                 // [R6]
                        begin
                            state_ff   <= C_RD;
                            ad_oe_n_ff <= 1'b0;                   // [R8]
                            ad_out_ff  <= {`ACDP_HS_RDATA,
                                           reg_hit(s_ad[7:0]) ?
                                           mem[reg_idx(s_ad[7:0])] :
                                           `ACDP_REG_RST};        // [R4] [R11]
                        end
                        else
                            state_ff <= C_WDATA;                  // [R12]
                    end
                end
                C_RD:
                begin
                    state_ff   <= C_ADDR;                         // [R10]
                    ad_oe_n_ff <= 1'b1;                           // [R8] [R10]
                end
                C_WDATA:
                    state_ff <= C_ADDR;                           // [R13]
                default:
                    state_ff <= C_ADDR;
            endcase
        end
    end

    assign wr_go = ctrl_edge & (state_ff == C_WDATA) &
                   (s_ad[9:8] == `ACDP_HS_WDATA) & reg_hit(addr_ff); // [R3] [R13]

    // Register file; pin inputs override port writes, error sets win last
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (i = 0; i < `ACDP_NREG; i = i + 1)
                mem[i] <= `ACDP_REG_RST;
        end
        else
        begin
            if (wr_go)
            begin
                if (reg_idx(addr_ff) == `ACDP_REG_FFLAGS)
                    // Flag bits clear on a one; upper bits store plainly
                    mem[`ACDP_REG_FFLAGS] <= (s_ad[7:0] & ~`ACDP_FFLAG_MASK) |
                                             (mem[`ACDP_REG_FFLAGS] & ~s_ad[7:0] &
                                              `ACDP_FFLAG_MASK);
                else
                    mem[reg_idx(addr_ff)] <= s_ad[7:0] & wmask(reg_idx(addr_ff)); // [R13]
            end
            for (i = 0; i < `ACDP_NPINS; i = i + 1)
            begin
                if (mem[`ACDP_REG_IODIR][i])
                    mem[cfg_reg(mem[`ACDP_REG_IOCFG0 + i][`ACDP_CFG_W-1:0])]
                       [cfg_bit(mem[`ACDP_REG_IOCFG0 + i][`ACDP_CFG_W-1:0])]
                       <= s_pin[i];                                // [R23]
            end
            // A new error in the clearing cycle must not be lost
            if (ff_err_set != 5'h00)
                mem[`ACDP_REG_FFLAGS][4:0] <= (wr_go && reg_idx(addr_ff) ==
                    `ACDP_REG_FFLAGS ? (mem[`ACDP_REG_FFLAGS][4:0] & ~s_ad[4:0]) :
                    mem[`ACDP_REG_FFLAGS][4:0]) | ff_err_set;     // [R11]
        end
    end

    // Pin bank: each pin shows the register bit its code selects
    genvar g;
    generate
        for (g = 0; g < `ACDP_NPINS; g = g + 1)
        begin : g_pin
            assign pin_val[g] =
                mem[cfg_reg(mem[`ACDP_REG_IOCFG0 + g][`ACDP_CFG_W-1:0])]
                   [cfg_bit(mem[`ACDP_REG_IOCFG0 + g][`ACDP_CFG_W-1:0])]; // [R23]
        end
    endgenerate

    // Registered pin drivers; an input pin is never driven
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out_ff  <= {`ACDP_NPINS{1'b0}};
            pin_oe_n_ff <= {`ACDP_NPINS{1'b1}};
        end
        else
        begin
            pin_out_ff  <= pin_val;
            pin_oe_n_ff <= mem[`ACDP_REG_IODIR];                  // [R23]
        end
    end

    // Checksum accumulates nine bits, wrapping like the standard sum
    assign sum_wide = {1'b0, sum_ff} + {1'b0, st2_ff[8:0]};
    assign sum_new  = (pos_ff == `ACDP_POS_DID) ? st2_ff[8:0] : sum_wide[8:0];
    assign csum_int = ~mem[`ACDP_REG_ANCCFG][`ACDP_ANC_CSUM];

    // Packet position of the word leaving the second buffer stage
    always @*
    begin
        take_first = (pos_ff == `ACDP_POS_DID);
        take_sum   = 1'b0;
        if (csum_int)                                              // [R19]
        begin
            if (pos_ff == `ACDP_POS_DC)
                take_sum = (st2_ff[7:0] == 8'h00);
            else if (pos_ff == `ACDP_POS_UDW)
                take_sum = (udw_left_ff == 8'h01);
        end
    end

    // Double buffer; a read-high edge in ancillary mode only flushes
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st1_ff      <= {`ACDP_AD_W{1'b0}};
            st1_v_ff    <= 1'b0;
            st2_ff      <= {`ACDP_AD_W{1'b0}};
            st2_v_ff    <= 1'b0;
            pos_ff      <= `ACDP_POS_DID;
            udw_left_ff <= 8'h00;
            sum_ff      <= 9'h000;
            hold_ff     <= {`ACDP_AD_W{1'b0}};
            hold_sum_ff <= 1'b0;
            csum_ff     <= {`ACDP_AD_W{1'b0}};
            emit_ff     <= E_IDLE;
        end
        else
        begin
            if (anc_edge)
            begin
                st1_ff   <= s_ad;                                  // [R16]
                st1_v_ff <= ~s_rd;                                 // [R15] [R21]
                st2_ff   <= st1_ff;
                st2_v_ff <= st1_v_ff;                              // [R21]
            end
            if (anc_edge && st2_v_ff)
            begin
                hold_ff     <= st2_ff;
                hold_sum_ff <= take_sum;
                sum_ff      <= sum_new;
                csum_ff     <= {~sum_new[8], sum_new};             // [R19]
                emit_ff     <= take_first ? E_ADF0 : E_WORD;       // [R20]
                case (pos_ff)
                    `ACDP_POS_DID:  pos_ff <= `ACDP_POS_SDID;      // [R15]
                    `ACDP_POS_SDID: pos_ff <= `ACDP_POS_DC;
                    `ACDP_POS_DC:
                    begin
                        udw_left_ff <= st2_ff[7:0];
                        pos_ff <= take_sum ? `ACDP_POS_DID : `ACDP_POS_UDW;
                    end
                    default:
                    begin
                        // Supplied checksum arrives with nothing left to count
                        if (udw_left_ff == 8'h00 || take_sum)
                            pos_ff <= `ACDP_POS_DID;
                        if (udw_left_ff != 8'h00)
                            udw_left_ff <= udw_left_ff - 8'h01;
                    end
                endcase
            end
            else
            begin
                // Burst of pushes finishes well inside one port clock period
                case (emit_ff)
                    E_ADF0:  emit_ff <= E_ADF1;
                    E_ADF1:  emit_ff <= E_ADF2;
                    E_ADF2:  emit_ff <= E_WORD;
                    E_WORD:  emit_ff <= hold_sum_ff ? E_SUM : E_IDLE;
                    E_SUM:   emit_ff <= E_IDLE;
                    default: emit_ff <= E_IDLE;
                endcase
            end
        end
    end

    // Registered FIFO write port
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            push_ff   <= 1'b0;
            word_ff   <= {`ACDP_AD_W{1'b0}};
            sop_ff    <= 1'b0;
            chroma_ff <= 1'b0;
        end
        else
        begin
            push_ff <= (emit_ff != E_IDLE);
            sop_ff  <= (emit_ff == E_ADF0);
            case (emit_ff)
                E_ADF0:  word_ff <= `ACDP_ADF0;                    // [R20]
                E_ADF1:  word_ff <= `ACDP_ADF1;
                E_ADF2:  word_ff <= `ACDP_ADF1;
                E_WORD:  word_ff <= hold_ff;
                E_SUM:   word_ff <= csum_ff;                       // [R19]
                default: word_ff <= word_ff;
            endcase
            if (emit_ff == E_ADF0)
                chroma_ff <= video_is_hd;                          // [R22]
        end
    end

    assign ad_out             = ad_out_ff;
    assign ad_oe_n            = ad_oe_n_ff;
    assign io_pin_out         = pin_out_ff;
    assign io_pin_oe_n        = pin_oe_n_ff;
    assign test_pattern_setup = mem[`ACDP_REG_TEST0];
    assign anc_push           = push_ff;
    assign anc_word           = word_ff;
    assign anc_sop            = sop_ff;
    assign anc_chroma_only    = chroma_ff;

endmodule

`default_nettype wire

// ---- core/acdp_map.vh ----
// Purpose: Shared constants of the ancillary/control data port.
// Assumes: Included by bare name from the core design files.
// Notes:   Register indices equal their byte offsets on the port.
`ifndef ACDP_MAP_VH
`define ACDP_MAP_VH

// Port bus layout
`define ACDP_AD_W        10
`define ACDP_DAT_W       8
`define ACDP_HS_ADDR     2'h0
`define ACDP_HS_WDATA    2'h3
`define ACDP_HS_RDATA    2'h2

// Port start-up
`define ACDP_INIT_EDGES  2'h3

// Register file
`define ACDP_NREG        32
`define ACDP_IDX_W       5
`define ACDP_REG_RST     8'h00
`define ACDP_REG_FFLAGS  5'h01
`define ACDP_REG_TEST0   5'h0D
`define ACDP_REG_IOCFG0  5'h0F
`define ACDP_REG_IODIR   5'h17
`define ACDP_REG_ANCCFG  5'h18
`define ACDP_FFLAG_MASK  8'h1F
`define ACDP_IOCFG_MASK  8'h3F
`define ACDP_FULL_MASK   8'hFF
`define ACDP_ANC_CSUM    0

// Multi-function pins
`define ACDP_NPINS       8
`define ACDP_CFG_W       6

// Ancillary framing
`define ACDP_ADF0        10'h000
`define ACDP_ADF1        10'h3FF
`define ACDP_POS_DID     2'h0
`define ACDP_POS_SDID    2'h1
`define ACDP_POS_DC      2'h2
`define ACDP_POS_UDW     2'h3

// Synchroniser vector: {pins, ad, rd, anc, port clock}
`define ACDP_SYNC_W      21
`define ACDP_S_CLK       0
`define ACDP_S_ANC       1
`define ACDP_S_RD        2
`define ACDP_S_AD_LO     3
`define ACDP_S_PIN_LO    13

`endif

// ---- core/acdp_sync.v ----
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Bits are independent levels; no word coherency is promised.
// Notes:   The first stage feeds only the second stage.
`default_nettype none

module acdp_sync #(
    parameter W = 1
) (
    input  wire         clk,     // Core clock
    input  wire         reset_n, // Async reset, active low
    input  wire [W-1:0] d,       // Asynchronous inputs
    output wire [W-1:0] q        // Synchronised outputs
);

    reg [W-1:0] meta_ff;
    reg [W-1:0] sync_ff;

    // Two stages to settle metastability
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= {W{1'b0}};
            sync_ff <= {W{1'b0}};
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

`default_nettype wire

// ---- tb/acdp_port_props.sv ----
// Purpose: Concurrent checks on the pins of the ancillary/control data port.
// Assumes: Host holds levels through each port clock high phase.
// Notes:   Lags of two or three clk come from the two-flop input sampling.
`default_nettype none
module acdp_port_props (
    input wire logic       clk,             // Core clock
    input wire logic       reset_n,         // Async reset, active low
    input wire logic       port_clk,        // Port clock pin
    input wire logic       anc_ctrl_sel,    // Ancillary or control select
    input wire logic       rd_wr_sel,       // Read or write select
    input wire logic [9:0] ad_in,           // Port bus input
    input wire logic [9:0] ad_out,          // Port bus output
    input wire logic       ad_oe_n,         // Bus enable, low drives
    input wire logic       video_is_hd,     // HD raster level
    input wire logic [7:0] test_pattern_setup, // Pattern setup register
    input wire logic       anc_push,        // FIFO write strobe
    input wire logic [9:0] anc_word,        // FIFO write word
    input wire logic       anc_sop,         // First word of a packet
    input wire logic       anc_chroma_only  // Chroma lane flag
);
    timeunit 1ns;
    timeprecision 100ps;
    wire [1:0] hs = ad_in[9:8];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Read drive starts only from a control read address edge
    a_rd_code: assert property (!ad_oe_n |-> ad_out[9:8] == 2'b10) else $error("read code wrong");
    a_drive_start: assert property ($fell(ad_oe_n) |-> port_clk && !anc_ctrl_sel && rd_wr_sel
        && $past(hs, 2) == 2'b00) else $error("drive without read address");
    a_drive_hold: assert property (!ad_oe_n && !port_clk |=> !ad_oe_n) else $error("drive dropped early");
    a_drive_release: assert property ($rose(ad_oe_n) |-> port_clk && !anc_ctrl_sel)
        else $error("release off edge");
    // Register only moves on a control write data edge
    a_reg_update: assert property ($changed(test_pattern_setup) |-> $past(port_clk, 2)
        && !$past(anc_ctrl_sel, 2) && !$past(rd_wr_sel, 2) && $past(hs, 2) == 2'b11)
        else $error("register changed without write");
    a_sop_word: assert property (anc_sop |-> anc_push && anc_word == 10'h000) else $error("sop word");
    a_flag_seq: assert property (anc_sop |=> anc_push && anc_word == 10'h3FF ##1 anc_push
        && anc_word == 10'h3FF) else $error("flag sequence");
    a_push_src: assert property ($rose(anc_push) |-> anc_ctrl_sel) else $error("push outside anc mode");
    a_chroma_lane: assert property (anc_sop |-> ##2 anc_chroma_only == $past(video_is_hd, 2))
        else $error("chroma flag");
    c_read: cover property ($fell(ad_oe_n));
    c_write: cover property ($changed(test_pattern_setup));
    c_packet: cover property (anc_sop);
endmodule

bind acdp_port acdp_port_props i_props (.clk, .reset_n, .port_clk, .anc_ctrl_sel, .rd_wr_sel, .ad_in,
    .ad_out, .ad_oe_n, .video_is_hd, .test_pattern_setup, .anc_push, .anc_word, .anc_sop, .anc_chroma_only);
`default_nettype wire

// ---- tb/acdp_host.sv ----
// Purpose: Host controller model driving the port pins.
// Assumes: Moves on the falling edge of clk; port clock period 170 ns.
// Notes:   A released bus reads low since the port inputs have pull-downs.
`default_nettype none
module acdp_host (
    input  wire logic       clk,          // Core clock
    input  wire logic [9:0] ad_out,       // Device bus drive value
    input  wire logic       ad_oe_n,      // Device drives when low
    output var  logic       port_clk,     // Port clock, still between transfers
    output var  logic       anc_ctrl_sel, // Ancillary or control select
    output var  logic       rd_wr_sel,    // Read or write select
    output wire logic [9:0] ad_in         // Resolved bus level
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [9:0] drv;
    logic       drv_en;
    // Wire level: device drive, else host drive, else pull-down
    assign ad_in = !ad_oe_n ? ad_out : (drv_en ? drv : 10'h000);
    // Idle levels from time zero
    initial
    begin
        {port_clk, anc_ctrl_sel, rd_wr_sel, drv_en, drv} = '0;
    end
    // One slow port clock period, far below the video clock rate; values held to the fall
    task pulse(input logic anc, input logic rd, input logic en, input logic [9:0] w);
        @(negedge clk);
        anc_ctrl_sel = anc;
        rd_wr_sel = rd;
        drv = w;
        drv_en = en;
        repeat (4) @(negedge clk);
        port_clk = 1'b1;
        repeat (8) @(negedge clk);
        port_clk = 1'b0;
        drv_en = 1'b0;
        repeat (4) @(negedge clk);
    endtask
    // Three idle clocks arm the port after any reset
    task init();
        repeat (3) pulse(1'b0, 1'b0, 1'b0, 10'h000);
    endtask
    task reg_wr(input logic [7:0] a, input logic [7:0] d);
        pulse(1'b0, 1'b0, 1'b1, {2'b00, a});
        pulse(1'b0, 1'b0, 1'b1, {2'b11, d});
    endtask
    // Bus sampled while the device drives, then a second clock ends the read
    task reg_rd(input logic [7:0] a, output logic [9:0] d, output logic oe_n);
        pulse(1'b0, 1'b1, 1'b1, {2'b00, a});
        d = ad_in;
        pulse(1'b0, 1'b1, 1'b0, 10'h000);
        oe_n = ad_oe_n;
    endtask
endmodule
`default_nettype wire

// ---- tb/acdp_port_test.sv ----
// Purpose: Self-checking bench for the ancillary/control data port.
// Assumes: Host model speaks the port protocol; pin inputs held low.
// Notes:   Expected packet words are built here from the framing rules.
`default_nettype none
module acdp_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic       clk, reset_n, video_is_hd, port_clk, anc_ctrl_sel, rd_wr_sel;
    logic       ad_oe_n, anc_push, anc_sop, anc_chroma_only, oe;
    logic [4:0] ff_err_set;
    logic [7:0] tps, pin_out, pin_oe_n;
    logic [9:0] ad_in, ad_out, anc_word, d;
    logic [9:0] got[$];
    int         num_errors, num_checks, sops, cycles;

    acdp_port i_dut (.clk(clk), .reset_n(reset_n), .port_clk(port_clk), .anc_ctrl_sel(anc_ctrl_sel),
        .rd_wr_sel(rd_wr_sel), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .io_pin_in(8'h00),
        .io_pin_out(pin_out), .io_pin_oe_n(pin_oe_n), .ff_err_set(ff_err_set), .video_is_hd(video_is_hd),
        .test_pattern_setup(tps), .anc_push(anc_push), .anc_word(anc_word), .anc_sop(anc_sop),
        .anc_chroma_only(anc_chroma_only));
    acdp_host i_host (.clk(clk), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .port_clk(port_clk),
        .anc_ctrl_sel(anc_ctrl_sel), .rd_wr_sel(rd_wr_sel), .ad_in(ad_in));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Collect FIFO pushes; a hang is cut short by the cycle ceiling
    always @(posedge clk)
    begin
        cycles++;
        if (anc_push)
        begin
            got.push_back(anc_word);
            sops += anc_sop;
        end
        if (cycles == 8000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task check(input logic [9:0] seen, input logic [9:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task finish_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // One packet, checksum from host or device
    task run_pkt(input logic sup);
        logic [9:0] w[$];
        logic [9:0] exp[$];
        logic [8:0] s;
        w = {10'h245, 10'h101, 10'h102, 10'h1AA, 10'h255};
        exp = {10'h000, 10'h3FF, 10'h3FF};
        s = '0;
        foreach (w[i]) s += w[i][8:0];
        got.delete();
        sops = 0;
        foreach (w[i]) i_host.pulse(1'b1, 1'b0, 1'b1, w[i]);
        if (sup) i_host.pulse(1'b1, 1'b0, 1'b1, {~s[8], s});
        repeat (2) i_host.pulse(1'b1, 1'b1, 1'b0, 10'h000);
        foreach (w[i]) exp.push_back(w[i]);
        exp.push_back({~s[8], s});
        check(10'(got.size()), 10'd9);
        foreach (exp[i]) check(got[i], exp[i]);
        check(10'(sops), 10'd1);
    endtask

    // Main sequence
    initial
    begin
        reset_n = 1'b0;
        ff_err_set = '0;
        video_is_hd = 1'b0;
        repeat (20) @(negedge clk);
        check(ad_oe_n, 1'b1);
        reset_n = 1'b1;
        i_host.init();
        i_host.reg_wr(8'h0D, 8'h27);
        check(tps, 10'h027);
        i_host.reg_rd(8'h0D, d, oe);
        check(d, 10'h227);
        check(oe, 1'b1);
        i_host.pulse(1'b0, 1'b0, 1'b1, 10'h00D);
        i_host.pulse(1'b0, 1'b0, 1'b1, 10'h1AA);
        check(tps, 10'h027);
        i_host.reg_wr(8'h0F, 8'hC8);
        i_host.reg_rd(8'h0F, d, oe);
        check(d, 10'h208);
        @(negedge clk) ff_err_set = 5'h15;
        @(negedge clk) ff_err_set = 5'h00;
        repeat (3) @(negedge clk);
        check(pin_out[0], 1'b1);
        check(pin_oe_n[0], 1'b0);
        i_host.reg_rd(8'h01, d, oe);
        check(d, 10'h215);
        i_host.reg_wr(8'h01, 8'h1F);
        i_host.reg_rd(8'h01, d, oe);
        check(d, 10'h200);
        check(pin_out[0], 1'b0);
        i_host.reg_rd(8'h20, d, oe);
        check(d, 10'h200);
        for (int m = 0; m < 2; m++)
        begin
            video_is_hd = m[0];
            i_host.reg_wr(8'h18, 8'(m));
            run_pkt(m[0]);
            check(anc_chroma_only, m[0]);
            check(tps, 10'h027);
            check(ad_oe_n, 1'b1);
        end
        // Reset in the middle of a read drive
        i_host.pulse(1'b0, 1'b1, 1'b1, 10'h00D);
        check(ad_oe_n, 1'b0);
        reset_n = 1'b0;
        repeat (2) @(negedge clk);
        check(ad_oe_n, 1'b1);
        check(tps, 10'h000);
        reset_n = 1'b1;
        i_host.init();
        i_host.reg_rd(8'h0D, d, oe);
        check(d, 10'h200);
        finish_test();
    end
endmodule
`default_nettype wire
